/* File: design/xb_defines.svh */
// Address map, register layout and sizing constants for the crossbar switch
`ifndef XB_DEFINES_SVH
`define XB_DEFINES_SVH

// ============================================================
// Register
`define XB_BRIDGE_CTRL_ADDR 32'h4000_0024
`define XB_BRIDGE_RST_BIT 0
`define XB_BRIDGE_CTRL_RESET 1'h1

// ============================================================
// On-chip memory regions
`define XB_ROM0_BASE 32'h0000_0000
`define XB_ROM0_END 32'h0003_FFFF
`define XB_ROM1_BASE 32'h0004_0000
`define XB_ROM1_END 32'h0005_FFFF
`define XB_RAM0_BASE 32'h1000_0000
`define XB_RAM0_END 32'h1003_FFFF

// ============================================================
// Peripheral configuration bus regions
`define XB_MEMCTL_BASE 32'h2000_0000
`define XB_MEMCTL_END 32'h2000_001F
`define XB_DEVCFG_BASE 32'h4000_0000
`define XB_DEVCFG_END 32'h4000_0083
`define XB_PERIPH_FIRST 8'h41
`define XB_PERIPH_LAST 8'h4A
`define XB_PERIPH_SPAN 32'h0000_02BF

// ============================================================
// Audio serializer data windows (top address byte)
`define XB_AUDIO_FIRST 8'h54
`define XB_AUDIO_LAST 8'h56

// ============================================================
// DMA engine register regions
`define XB_DMACTL_BASE 32'h6000_0000
`define XB_DMACTL_END 32'h6000_008F
`define XB_DMAHI_EVT_BASE 32'h6100_8000
`define XB_DMAHI_EVT_END 32'h6100_807F
`define XB_DMAHI_XFR_BASE 32'h6100_80A0
`define XB_DMAHI_XFR_END 32'h6100_81FF
`define XB_DMALO_EVT_BASE 32'h6200_8000
`define XB_DMALO_EVT_END 32'h6200_807F
`define XB_DMALO_XFR_BASE 32'h6200_80A0
`define XB_DMALO_XFR_END 32'h6200_81FF

// ============================================================
// External memory regions
`define XB_SDRAM_BASE 32'h8000_0000
`define XB_SDRAM_END 32'h8FFF_FFFF
`define XB_ASYNC_BASE 32'h9000_0000
`define XB_ASYNC_END 32'h9FFF_FFFF
`define XB_EMCTL_BASE 32'hF000_0000
`define XB_EMCTL_END 32'hF000_00BF
`define XB_SDRAM_CONFIG_REGISTER_ADDR 32'hF000_0008
`define XB_SDRAM_CONFIG_REGISTER_TOP_BE 4'h8

// ============================================================
// Sizing
`define XB_NUM_MASTERS 5
`define XB_NUM_TARGETS 5
`define XB_FIFO_DEPTH 4
`define XB_FULL_BE 4'hF

`endif

/* File: design/xb_pkg.sv */
// Types shared by the crossbar switch, its property checks and its bench
package xb_pkg;

  // ============================================================
  // Masters and targets
  typedef enum logic [2:0] {
    XB_M_CPU = 3'h0,
    XB_M_FILL = 3'h1,
    XB_M_DMAHI = 3'h2,
    XB_M_DMALO = 3'h3,
    XB_M_HOST = 3'h4
  } xb_master_t;

  typedef enum logic [2:0] {
    XB_T_ONCHIP = 3'h0,
    XB_T_EXTMEM = 3'h1,
    XB_T_PERIPH = 3'h2,
    XB_T_AUDIO = 3'h3,
    XB_T_DMAREG = 3'h4
  } xb_target_t;

  // ============================================================
  // Per-target arbiter state and address decode result
  typedef enum logic {
    XB_ARB_IDLE = 1'b0,
    XB_ARB_BUSY = 1'b1
  } xb_arb_t;

  typedef struct packed {
    logic ok;
    logic word_only;
    xb_target_t tgt;
  } xb_dec_t;

endpackage

/* File: design/xb_bridge_fifo.sv */
// Bridge FIFO with registered head data and synchronous flush
`timescale 1ns/100ps
module xb_bridge_fifo #(
  parameter int W = 72,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("xb_bridge_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0] cnt_q;
  logic [W-1:0] out_q;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;

  assign in_ready = (cnt_q != FULL) && !flush;
  assign out_valid = (cnt_q != '0);
  assign rd_d = do_pop ? rd_q + AW'(1) : rd_q;
  assign out_data = out_q;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Head is re-read every cycle; bypass covers a write into the head slot
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= '0;
    end else if (do_push && wr_q == rd_d) begin
      out_q <= in_data;
    end else begin
      out_q <= mem_q[rd_d];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= do_push ? wr_q + AW'(1) : wr_q;
      rd_q <= rd_d;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

/* File: design/xb_crossbar.sv */
// Five-master, five-target crossbar switch with per-target arbitration and bridges
`timescale 1ns/100ps
`include "xb_defines.svh"
module xb_crossbar #(
  parameter int NM = `XB_NUM_MASTERS,
  parameter int NT = `XB_NUM_TARGETS,
  parameter int DEPTH = `XB_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NM-1:0] m_req,
  input wire logic [NM-1:0][31:0] m_addr,
  input wire logic [NM-1:0] m_we,
  input wire logic [NM-1:0][3:0] m_be,
  input wire logic [NM-1:0][31:0] m_wdata,
  output logic [NM-1:0] m_done,
  output logic [NM-1:0] m_err,
  output logic [NM-1:0][31:0] m_rdata,
  output logic [NT-1:0] t_req,
  output logic [NT-1:0][31:0] t_addr,
  output logic [NT-1:0] t_we,
  output logic [NT-1:0][3:0] t_be,
  output logic [NT-1:0][31:0] t_wdata,
  output xb_pkg::xb_master_t [NT-1:0] t_master,
  input wire logic [NT-1:0] t_done,
  input wire logic [NT-1:0][31:0] t_rdata,
  output logic bridge_held
);
  import xb_pkg::*;

  if (NM != 5 || NT != 5) begin : g_bad_size
    $error("xb_crossbar: the map and priority order serve five masters and five targets");
  end

  localparam int PW = 32 + 1 + 4 + 32 + 3;

  // ============================================================
  // Address decode
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic xb_dec_t decode(input logic [31:0] a);
    xb_dec_t d;
    d = '{ok: 1'b0, word_only: 1'b1, tgt: XB_T_PERIPH};
    if (in_rng(a, `XB_ROM0_BASE, `XB_ROM0_END) || in_rng(a, `XB_ROM1_BASE, `XB_ROM1_END) ||
        in_rng(a, `XB_RAM0_BASE, `XB_RAM0_END)) begin
      d = '{ok: 1'b1, word_only: 1'b0, tgt: XB_T_ONCHIP};
    end else if (in_rng(a, `XB_MEMCTL_BASE, `XB_MEMCTL_END) ||
                 in_rng(a, `XB_DEVCFG_BASE, `XB_DEVCFG_END)) begin
      d = '{ok: 1'b1, word_only: 1'b1, tgt: XB_T_PERIPH};
    end else if (a[31:24] >= `XB_PERIPH_FIRST && a[31:24] <= `XB_PERIPH_LAST &&
                 a[23:0] <= `XB_PERIPH_SPAN) begin
      d = '{ok: 1'b1, word_only: 1'b1, tgt: XB_T_PERIPH};
    end else if (a[31:24] >= `XB_AUDIO_FIRST && a[31:24] <= `XB_AUDIO_LAST) begin
      d = '{ok: 1'b1, word_only: 1'b1, tgt: XB_T_AUDIO};
    end else if (in_rng(a, `XB_DMACTL_BASE, `XB_DMACTL_END)) begin
      d = '{ok: 1'b1, word_only: 1'b1, tgt: XB_T_DMAREG};
    end else if (in_rng(a, `XB_DMAHI_EVT_BASE, `XB_DMAHI_EVT_END) ||
                 in_rng(a, `XB_DMAHI_XFR_BASE, `XB_DMAHI_XFR_END) ||
                 in_rng(a, `XB_DMALO_EVT_BASE, `XB_DMALO_EVT_END) ||
                 in_rng(a, `XB_DMALO_XFR_BASE, `XB_DMALO_XFR_END)) begin
      d = '{ok: 1'b1, word_only: 1'b0, tgt: XB_T_DMAREG};
    end else if (in_rng(a, `XB_SDRAM_BASE, `XB_SDRAM_END) ||
                 in_rng(a, `XB_ASYNC_BASE, `XB_ASYNC_END)) begin
      d = '{ok: 1'b1, word_only: 1'b0, tgt: XB_T_EXTMEM};
    end else if (in_rng(a, `XB_EMCTL_BASE, `XB_EMCTL_END)) begin
      d = '{ok: 1'b1, word_only: 1'b1, tgt: XB_T_EXTMEM};
    end
    // Emulation region and gaps fall through as unmapped
    decode = d;
  endfunction

  // Fixed order: CPU, DMA high, DMA low, host, then cache fill last
  function automatic xb_master_t pick(input logic [NM-1:0] c);
    if (c[XB_M_CPU]) begin
      pick = XB_M_CPU;
    end else if (c[XB_M_DMAHI]) begin
      pick = XB_M_DMAHI;
    end else if (c[XB_M_DMALO]) begin
      pick = XB_M_DMALO;
    end else if (c[XB_M_HOST]) begin
      pick = XB_M_HOST;
    end else begin
      pick = XB_M_FILL;
    end
  endfunction

  // ============================================================
  // Master-side qualification
  logic bridge_rst_q;
  logic [NM-1:0] issued_q;
  logic [NM-1:0] m_done_q;
  logic [NM-1:0] m_err_q;
  logic [NM-1:0][31:0] m_rdata_q;
  xb_dec_t [NM-1:0] dec;
  logic [NM-1:0] bad;
  logic [NM-1:0] want;
  logic [NM-1:0] reg_hit;

  genvar gm;
  for (gm = 0; gm < NM; gm++) begin : g_master
    wire sdram_config_register_byte = (m_addr[gm][31:2] == `XB_SDRAM_CONFIG_REGISTER_ADDR >> 2) &&
                     (m_be[gm] == `XB_SDRAM_CONFIG_REGISTER_TOP_BE);
    wire size_bad = dec[gm].word_only && (m_be[gm] != `XB_FULL_BE) && !sdram_config_register_byte;
    // Cache fill only reaches external memory; CPU data never uses the memory-side bridge
    wire path_bad = (gm == int'(XB_M_FILL) && dec[gm].tgt != XB_T_EXTMEM) ||
                    (gm == int'(XB_M_CPU) && dec[gm].tgt == XB_T_ONCHIP);
    assign dec[gm] = decode(m_addr[gm]);
    assign bad[gm] = !dec[gm].ok || size_bad || path_bad;
    assign want[gm] = m_req[gm] && !issued_q[gm] && !bad[gm];
    assign reg_hit[gm] = (m_addr[gm][31:2] == `XB_BRIDGE_CTRL_ADDR >> 2);
  end

  // ============================================================
  // Per-target arbiters and bridges
  xb_arb_t [NT-1:0] state_q;
  xb_master_t [NT-1:0] owner_q;
  xb_master_t [NT-1:0] win;
  logic [NT-1:0] grant;
  logic [NT-1:0] local_acc;
  logic [NT-1:0] fifo_ready;
  logic [NT-1:0] flush;
  logic [NT-1:0] finish;

  genvar gt;
  for (gt = 0; gt < NT; gt++) begin : g_target
    logic [NM-1:0] cand;
    logic [PW-1:0] pay_in;
    logic [PW-1:0] pay_out;
    logic sh_ready;
    logic sh_valid;
    logic [PW-1:0] sh_out;
    logic fl_ready;
    logic fl_valid;
    logic [PW-1:0] fl_out;
    xb_arb_t arb_q;
    xb_master_t own_q;
    wire blocked = (gt == int'(XB_T_ONCHIP)) && bridge_rst_q;
    wire to_fill = (gt == int'(XB_T_EXTMEM)) && (win[gt] == XB_M_FILL);

    for (gm = 0; gm < NM; gm++) begin : g_cand
      assign cand[gm] = want[gm] && dec[gm].tgt == xb_target_t'(gt);
    end

    assign win[gt] = pick(cand);
    assign grant[gt] = (state_q[gt] == XB_ARB_IDLE) && (|cand) && fifo_ready[gt] &&
                       !blocked;
    assign local_acc[gt] = (gt == int'(XB_T_PERIPH)) && reg_hit[win[gt]];
    assign flush[gt] = blocked;
    assign finish[gt] = (state_q[gt] == XB_ARB_BUSY) && ((t_req[gt] && t_done[gt]) ||
                        flush[gt]);
    assign pay_in = {m_addr[win[gt]], m_we[win[gt]], m_be[win[gt]], m_wdata[win[gt]],
                     win[gt]};
    assign {t_addr[gt], t_we[gt], t_be[gt], t_wdata[gt]} = pay_out[PW-1:3];
    assign t_master[gt] = xb_master_t'(pay_out[2:0]);
    // One access per target in flight, so the two heads never compete
    assign pay_out = fl_valid ? fl_out : sh_out;
    assign t_req[gt] = sh_valid || fl_valid;
    assign fifo_ready[gt] = to_fill ? fl_ready : sh_ready;

    // Shared bridge for every master except cache fills
    xb_bridge_fifo #(
      .W(PW),
      .DEPTH(DEPTH)
    ) u_bridge (
      .clk(clk),
      .rst(rst),
      .flush(flush[gt]),
      .in_valid(grant[gt] && !local_acc[gt] && !to_fill),
      .in_ready(sh_ready),
      .in_data(pay_in),
      .out_valid(sh_valid),
      .out_ready(t_done[gt] && !fl_valid),
      .out_data(sh_out)
    );

    // Fills reach external memory through a bridge of their own
    if (gt == int'(XB_T_EXTMEM)) begin : g_fill
      xb_bridge_fifo #(
        .W(PW),
        .DEPTH(DEPTH)
      ) u_fill_bridge (
        .clk(clk),
        .rst(rst),
        .flush(flush[gt]),
        .in_valid(grant[gt] && to_fill),
        .in_ready(fl_ready),
        .in_data(pay_in),
        .out_valid(fl_valid),
        .out_ready(t_done[gt] && fl_valid),
        .out_data(fl_out)
      );
    end else begin : g_no_fill
      assign fl_ready = 1'b0;
      assign fl_valid = 1'b0;
      assign fl_out = '0;
    end

    // Local registers keep each arbiter a single driver of its own state
    always_ff @(posedge clk) begin
      if (rst) begin
        arb_q <= XB_ARB_IDLE;
        own_q <= XB_M_CPU;
      end else begin
        case (arb_q)
          XB_ARB_IDLE: begin
            if (grant[gt] && !local_acc[gt]) begin
              arb_q <= XB_ARB_BUSY;
              own_q <= win[gt];
            end
          end
          XB_ARB_BUSY: begin
            if (finish[gt]) begin
              arb_q <= XB_ARB_IDLE;
            end
          end
          default: begin
            arb_q <= XB_ARB_IDLE;
          end
        endcase
      end
    end

    assign state_q[gt] = arb_q;
    assign owner_q[gt] = own_q;
  end

  // ============================================================
  // Completion back to masters
  logic [NM-1:0] done_d;
  logic [NM-1:0] err_d;
  logic [NM-1:0][31:0] rdata_d;
  logic [NM-1:0] grant_m;

  always_comb begin
    done_d = '0;
    err_d = '0;
    rdata_d = m_rdata_q;
    grant_m = '0;
    for (int m = 0; m < NM; m++) begin
      if (m_req[m] && !issued_q[m] && bad[m]) begin
        done_d[m] = 1'b1;
        err_d[m] = 1'b1;
        rdata_d[m] = '0;
      end
      for (int t = 0; t < NT; t++) begin
        if (grant[t] && win[t] == xb_master_t'(m)) begin
          grant_m[m] = 1'b1;
          if (local_acc[t]) begin
            done_d[m] = 1'b1;
            rdata_d[m] = {31'h0, bridge_rst_q};
          end
        end
        if (finish[t] && owner_q[t] == xb_master_t'(m)) begin
          done_d[m] = 1'b1;
          err_d[m] = flush[t];
          rdata_d[m] = flush[t] ? 32'h0 : t_rdata[t];
        end
      end
    end
  end

  // Issued stays set through the done cycle so a held request is not taken twice
  always_ff @(posedge clk) begin
    if (rst) begin
      issued_q <= '0;
      m_done_q <= '0;
      m_err_q <= '0;
      m_rdata_q <= '0;
    end else begin
      issued_q <= (issued_q & ~m_done_q) | grant_m | (m_req & ~issued_q & bad);
      m_done_q <= done_d;
      m_err_q <= err_d;
      m_rdata_q <= rdata_d;
    end
  end

  // ============================================================
  // Bridge reset control register
  wire ctl_wr = grant[XB_T_PERIPH] && local_acc[XB_T_PERIPH] && m_we[win[XB_T_PERIPH]] &&
                m_be[win[XB_T_PERIPH]][0];

  always_ff @(posedge clk) begin
    if (rst) begin
      bridge_rst_q <= `XB_BRIDGE_CTRL_RESET;
    end else if (ctl_wr) begin
      bridge_rst_q <= m_wdata[win[XB_T_PERIPH]][`XB_BRIDGE_RST_BIT];
    end
  end

  assign m_done = m_done_q;
  assign m_err = m_err_q;
  assign m_rdata = m_rdata_q;
  assign bridge_held = bridge_rst_q;
endmodule

/* File: tb/xb_target_model.sv */
// Target-side model that answers each crossbar target after a set wait
`timescale 1ns/100ps
module xb_target_model #(
  parameter int NT = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic [NT-1:0] t_req,
  input wire logic [NT-1:0][31:0] t_addr,
  input wire logic [NT-1:0] t_we,
  input wire logic [NT-1:0][3:0] t_be,
  input wire logic [NT-1:0][31:0] t_wdata,
  output logic [NT-1:0] t_done,
  output logic [NT-1:0][31:0] t_rdata
);
  logic [NT-1:0][3:0] wait_q;
  logic [31:0] noise_q;

  // ==========
  // Answer timing
  always_ff @(posedge clk) begin
    noise_q <= rst ? 32'h0 : noise_q + 32'h9E37_79B9;
    for (int i = 0; i < NT; i++) begin
      if (rst || t_done[i] || !t_req[i]) begin
        wait_q[i] <= 4'h0;
        t_done[i] <= 1'b0;
      end else begin
        wait_q[i] <= wait_q[i] + 4'h1;
        t_done[i] <= (wait_q[i] >= lat);
      end
    end
  end

  // Data lines churn outside the answer cycle so stale values never match
  // Answer folds in the whole payload so a lost write field shows up
  for (genvar i = 0; i < NT; i++) begin : g_rd
    assign t_rdata[i] = t_done[i] ? (t_addr[i] ^ t_wdata[i] ^ {t_we[i], 3'h0, t_be[i], 24'h0} ^
                        32'hA5A5_0000 ^ 32'(i)) : (noise_q ^ 32'(i));
  end
endmodule

/* File: tb/xb_crossbar_properties.sv */
// Concurrent checks on the crossbar switch ports
`timescale 1ns/100ps
`include "xb_defines.svh"
module xb_crossbar_properties
  import xb_pkg::*;
#(
  parameter int NM = 5,
  parameter int NT = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NM-1:0] m_req,
  input wire logic [NM-1:0][31:0] m_addr,
  input wire logic [NM-1:0] m_we,
  input wire logic [NM-1:0][3:0] m_be,
  input wire logic [NM-1:0] m_done,
  input wire logic [NM-1:0] m_err,
  input wire logic [NM-1:0][31:0] m_rdata,
  input wire logic [NT-1:0] t_req,
  input wire logic [NT-1:0][31:0] t_addr,
  input xb_pkg::xb_master_t [NT-1:0] t_master,
  input wire logic [NT-1:0] t_done,
  input wire logic bridge_held
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_fwd(t, m);
    t_req[t] && t_done[t] && t_master[t] == m |=> m_done[m] && !m_err[m];
  endproperty

  // ==========
  // Assertions and cover points
  AST_HELD_AFTER_RESET: assert property (disable iff (1'b0) rst |=> bridge_held)
    else $error("bridge not held after reset");
  AST_CTRL_READ: assert property ($rose(m_req[0]) && !m_we[0] && !t_req[2] &&
    m_addr[0] == `XB_BRIDGE_CTRL_ADDR |=> m_done[0] && m_rdata[0] == {31'h0, bridge_held})
    else $error("control read wrong");
  AST_HELD_BLOCKS: assert property (bridge_held && $past(bridge_held) |-> !t_req[0])
    else $error("held bridge passed a transfer");
  AST_EMU_REFUSED: assert property ($rose(m_req[0]) && m_addr[0][31:28] == 4'h3
    |=> m_done[0] && m_err[0])
    else $error("emulation region not refused");
  AST_BYTE_REFUSED: assert property ($rose(m_req[2]) && m_addr[2][31:24] == 8'h54 &&
    m_be[2] != 4'hF |=> m_done[2] && m_err[2])
    else $error("byte access to word-only taken");
  AST_AUDIO_ROUTE: assert property ($rose(m_req[2]) && m_addr[2][31:24] == 8'h54 &&
    m_be[2] == 4'hF && !t_req[3] && !m_req[0] |=> t_req[3] && t_master[3] == XB_M_DMAHI)
    else $error("audio window not routed");
  AST_DMA_PRIORITY: assert property ($rose(t_req[2]) && !m_done[2] &&
    $past(m_req[2] && m_req[3] && !m_req[0] && m_addr[2][31:28] == 4'h4 &&
    m_addr[3][31:28] == 4'h4) |-> t_master[2] == XB_M_DMAHI)
    else $error("low DMA won over high DMA");
  AST_HOLD_OWNER: assert property (t_req[1] && !t_done[1] |=> t_req[1] &&
    $stable(t_master[1]) && $stable(t_addr[1]))
    else $error("owner changed before completion");
  AST_FWD_PERIPH: assert property (p_fwd(2, 2))
    else $error("peripheral answer not returned");
  AST_FWD_FILL: assert property (p_fwd(1, 1))
    else $error("fill answer not returned");

  COV_PARALLEL: cover property (t_req[2] && t_req[3] && t_req[4]);
  COV_FLUSH: cover property ($rose(bridge_held));
  COV_STALL: cover property (m_req[3] && t_master[2] == XB_M_DMAHI);
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the crossbar switch
`timescale 1ns/100ps
`include "xb_defines.svh"
module tb;
  import xb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] m_req = '0, m_we = '0, m_done, m_err, t_req, t_done, t_we;
  logic [4:0][31:0] m_addr = '0, m_wdata = '0, m_rdata, t_addr, t_rdata, t_wdata;
  logic [4:0][3:0] m_be = '0, t_be;
  xb_master_t [4:0] t_master;
  logic bridge_held;
  logic [3:0] lat = 4'h0;
  int fail_count = 0, check_count = 0, cyc = 0;
  int done_cyc [5];
  logic [31:0] rd, d0;
  logic er, e0;

`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", name, (exp), (got)); end end

  always #5 clk = ~clk;

  xb_crossbar xb_crossbar_inst (.clk, .rst, .m_req, .m_addr, .m_we, .m_be, .m_wdata, .m_done,
    .m_err, .m_rdata, .t_req, .t_addr, .t_we, .t_be, .t_wdata, .t_master, .t_done,
    .t_rdata, .bridge_held);
  xb_target_model xb_target_model_inst (.clk, .rst, .lat, .t_req, .t_addr, .t_we, .t_be,
    .t_wdata, .t_done, .t_rdata);

  task automatic finish_test();
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Request held from a falling edge until the done pulse is seen
  task automatic access(input int m, input logic [31:0] a, input logic w, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] d, output logic e);
    int n;
    @(negedge clk);
    m_addr[m] = a;
    m_we[m] = w;
    m_be[m] = be;
    m_wdata[m] = wd;
    m_req[m] = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (m_done[m] !== 1'b1 && n < 200);
    `CHK("done", 1'b1, m_done[m]);
    d = m_rdata[m];
    e = m_err[m];
    done_cyc[m] = cyc;
    m_req[m] = 1'b0;
  endtask

  task automatic t_reg();
    access(0, `XB_BRIDGE_CTRL_ADDR, 1'b0, 4'hF, 32'h0, rd, er);
    `CHK("ctrl reset", 32'h1, rd);
    `CHK("held reset", 1'b1, bridge_held);
    access(0, `XB_BRIDGE_CTRL_ADDR, 1'b1, 4'hF, 32'h0, rd, er);
    access(0, `XB_BRIDGE_CTRL_ADDR, 1'b0, 4'hF, 32'h0, rd, er);
    `CHK("ctrl cleared", 32'h0, rd);
    `CHK("held cleared", 1'b0, bridge_held);
  endtask

  // Entries: master, expected target (E refused), byte enables, address
  task automatic t_map();
    logic [43:0] tab [14] = '{44'h20F_1000_0000, 44'h201_0004_0000, 44'h22F_4000_0080,
      44'h2EF_4000_0084, 44'h23F_54FF_FFFC, 44'h2E1_5400_0000, 44'h242_6100_807C,
      44'h2EF_6100_8080, 44'h21F_9FFF_FFFC, 44'h0EF_3000_0000, 44'h218_F000_0008,
      44'h2E4_F000_0008, 44'h11F_8000_0000, 44'h1EF_4000_0080};
    logic [31:0] expd;
    lat = 4'h1;
    foreach (tab[i]) begin
      access(int'(tab[i][43:40]), tab[i][31:0], 1'b0, tab[i][35:32], 32'h0, rd, er);
      `CHK("map err", tab[i][39:36] == 4'hE, er);
      expd = tab[i][31:0] ^ {4'h0, tab[i][35:32], 24'h0} ^ 32'hA5A5_0000 ^ 32'(tab[i][39:36]);
      if (tab[i][39:36] != 4'hE)
        `CHK("map data", expd, rd);
    end
  endtask

  task automatic t_prio();
    logic [31:0] d [5];
    logic e [5];
    lat = 4'h3;
    fork
      access(4, 32'h4000_0040, 1'b1, 4'hF, 32'h0, d[4], e[4]);
      access(3, 32'h4000_0040, 1'b1, 4'hF, 32'h1234_5678, d[3], e[3]);
      access(2, 32'h4000_0080, 1'b0, 4'hF, 32'h0, d[2], e[2]);
    join
    `CHK("high first", 1'b1, done_cyc[2] < done_cyc[3]);
    `CHK("low before host", 1'b1, done_cyc[3] < done_cyc[4]);
    `CHK("periph data", 32'h4000_0080 ^ 32'hA5A5_0002 ^ 32'h0F00_0000, d[2]);
    `CHK("wr echo", 32'h4000_0040 ^ 32'h1234_5678 ^ 32'h8F00_0000 ^ 32'hA5A5_0002, d[3]);
    `CHK("prio err", 1'b0, e[2] | e[3] | e[4]);
  endtask

  task automatic t_par();
    logic [31:0] d [5];
    logic e [5];
    lat = 4'h2;
    fork
      access(0, 32'h8000_0100, 1'b0, 4'hF, 32'h0, d[0], e[0]);
      access(1, 32'h8000_0200, 1'b0, 4'hF, 32'h0, d[1], e[1]);
      access(2, 32'h5500_0000, 1'b1, 4'hF, 32'h0, d[2], e[2]);
      access(3, 32'h6200_8000, 1'b1, 4'hF, 32'h0, d[3], e[3]);
      access(4, 32'h1000_0010, 1'b0, 4'hF, 32'h0, d[4], e[4]);
    join
    `CHK("parallel", 1'b1, done_cyc[2] == done_cyc[3] && done_cyc[3] == done_cyc[4]);
    `CHK("cpu beside dma", done_cyc[2], done_cyc[0]);
    `CHK("fill last", 1'b1, done_cyc[1] > done_cyc[0]);
    `CHK("fill data", 32'h8000_0200 ^ 32'hA5A5_0001 ^ 32'h0F00_0000, d[1]);
    `CHK("par err", 1'b0, e[0] | e[1] | e[2] | e[3] | e[4]);
  endtask

  task automatic t_flush();
    lat = 4'hF;
    fork
      access(4, 32'h1000_0000, 1'b0, 4'hF, 32'h0, rd, er);
      begin
        repeat (5) @(negedge clk);
        access(0, `XB_BRIDGE_CTRL_ADDR, 1'b1, 4'hF, 32'h1, d0, e0);
      end
    join
    `CHK("flush err", 1'b1, er);
    `CHK("flush data", 32'h0, rd);
    `CHK("held set", 1'b1, bridge_held);
    lat = 4'h1;
    fork
      access(4, 32'h1003_FFFC, 1'b0, 4'hF, 32'h0, rd, er);
      begin
        repeat (10) @(negedge clk);
        `CHK("held blocks", 1'b0, t_req[0] || done_cyc[4] > cyc - 9);
        access(0, `XB_BRIDGE_CTRL_ADDR, 1'b1, 4'hF, 32'h0, d0, e0);
      end
    join
    `CHK("after release", 32'h1003_FFFC ^ 32'hA5A5_0000 ^ 32'h0F00_0000, rd);
    `CHK("release err", 1'b0, er);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reg();
    t_map();
    t_prio();
    t_par();
    t_flush();
    finish_test();
  end
endmodule

bind xb_crossbar xb_crossbar_properties #(.NM(NM), .NT(NT)) xb_crossbar_properties_inst (.clk,
  .rst, .m_req, .m_addr, .m_we, .m_be, .m_done, .m_err, .m_rdata, .t_req, .t_addr, .t_master,
  .t_done, .bridge_held);
